// ==== design/ascp_regs.svh ====
`ifndef ASCP_REGS_SVH
`define ASCP_REGS_SVH
// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define ASCP_SOFT_RESET_CONTROL 7'h00
`define ASCP_FORMAT_AND_POWER_CONTROL 7'h01
`define ASCP_FMT_RESET 8'h00
`define ASCP_SOFT_RESET_BIT 7
`define ASCP_DUTY_STAB_DIS_BIT 7
`define ASCP_SCRAMBLE_BIT 6
`define ASCP_SIGNED_BIT 5
`define ASCP_SLEEP_BIT 4
// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define ASCP_FRAME_BITS 5'd16
`define ASCP_DATA_START 5'd8
`define ASCP_SLEEP_PULSE 4'd8
`endif

// ==== design/ascp_pkg.sv ====
package ascp_pkg;
    // frame receiver states
    typedef enum logic [1:0] {
        ASCP_IDLE = 2'b00,
        ASCP_SHIFT = 2'b01,
        ASCP_DONE = 2'b10
    } ascp_state_t;
endpackage : ascp_pkg

// ==== design/ascp_sync_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// synchronised pin levels and edges
// ----------------------------------------------------------------------
interface ascp_sync_if;
    logic cs_n; // chip select level
    logic sck; // serial clock level
    logic sdi; // data in level
    logic sdo_in; // sdo pin level as input
    logic cs_fall; // chip select falling edge
    logic cs_rise; // chip select rising edge
    logic sck_rise; // sck rising edge
    logic sck_fall; // sck falling edge
    modport src (output cs_n, sck, sdi, sdo_in, cs_fall, cs_rise,
        sck_rise, sck_fall);
    modport dst (input cs_n, sck, sdi, sdo_in, cs_fall, cs_rise,
        sck_rise, sck_fall);
endinterface : ascp_sync_if
`default_nettype wire

// ==== design/ascp_pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// three-stage pin synchroniser with edge detect
// ----------------------------------------------------------------------
module ascp_pin_sync (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] pins,
    ascp_sync_if.src sy
);
    logic [3:0] s1; // first stage, read only by s2
    logic [3:0] s2; // second stage
    logic [3:0] s3; // third stage
    logic [3:0] lvl; // accepted level

    // shift chain; idle levels: cs high, others low
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s1 <= 4'h1;
            s2 <= 4'h1;
            s3 <= 4'h1;
        end else begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lvl <= 4'h1;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (s2[i] == s3[i]) begin
                    lvl[i] <= s3[i];
                end
            end
        end
    end

    assign sy.cs_n = lvl[0];
    assign sy.sck = lvl[1];
    assign sy.sdi = lvl[2];
    assign sy.sdo_in = lvl[3];
    assign sy.cs_fall = lvl[0] && (s2[0] == s3[0]) && !s3[0];
    assign sy.cs_rise = !lvl[0] && (s2[0] == s3[0]) && s3[0];
    assign sy.sck_rise = !lvl[1] && (s2[1] == s3[1]) && s3[1];
    assign sy.sck_fall = lvl[1] && (s2[1] == s3[1]) && !s3[1];
endmodule : ascp_pin_sync
`default_nettype wire

// ==== design/ascp_serial_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ascp_regs.svh"
module ascp_serial_port (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic port_style_strap,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic sdi_pin,
    input wire logic sdo_pin_in,
    output logic sdo_out,
    output logic sdo_oe,
    output logic duty_stabilizer_disable,
    output logic output_scramble_enable,
    output logic signed_coding_select,
    output logic sleep_all,
    output logic [3:0] nap_channel,
    output logic two_lane_16bit,
    output logic drive_half_current,
    output logic term_enable,
    output logic [13:0] scrambled_data,
    input wire logic [13:0] raw_data
);
    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    ascp_sync_if sy ();
    ascp_pin_sync u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pins({sdo_pin_in, sdi_pin, sck_pin, cs_n_pin}),
        .sy(sy)
    );

    logic [2:0] strap_q; // strap synchroniser
    logic serial_mode; // strap low, settled
    logic [7:0] fmt; // format_and_power_control
    logic [15:0] shreg; // received frame bits
    logic [4:0] bit_cnt; // sck rises seen
    ascp_pkg::ascp_state_t state; // receiver state
    logic [7:0] rd_data; // latched readback byte
    logic rd_active; // readback frame in flight
    logic [3:0] sleep_cnt; // soft reset sleep pulse
    logic soft_reset_bit; // reset bit, self clearing

    // decode the index field
    function automatic logic is_index(input logic [6:0] idx,
        input logic [6:0] want);
        return idx == want;
    endfunction : is_index

    // ------------------------------------------------------------------
    // strap sampling
    // ------------------------------------------------------------------
    // strap is a pin, so it passes three flops too
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            strap_q <= 3'h7;
            serial_mode <= 1'b0;
        end else begin
            strap_q <= {strap_q[1:0], port_style_strap};
            if (strap_q[1] == strap_q[2]) begin
                serial_mode <= !strap_q[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // frame receiver
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst || !serial_mode) begin
            // parallel mode does no framing at all
            state <= ascp_pkg::ASCP_IDLE;
            bit_cnt <= 5'd0;
            shreg <= 16'h0000;
        end else if (sy.cs_rise) begin
            state <= ascp_pkg::ASCP_IDLE;
            bit_cnt <= 5'd0;
        end else begin
            unique case (state)
                ascp_pkg::ASCP_IDLE: begin
                    if (sy.cs_fall) begin
                        state <= ascp_pkg::ASCP_SHIFT;
                        bit_cnt <= 5'd0;
                    end
                end
                ascp_pkg::ASCP_SHIFT: begin
                    if (sy.sck_rise) begin
                        // direction first, then index, then data
                        shreg <= {shreg[14:0], sy.sdi};
                        bit_cnt <= bit_cnt + 5'd1;
                        if (bit_cnt == `ASCP_FRAME_BITS - 5'd1) begin
                            state <= ascp_pkg::ASCP_DONE;
                        end
                    end
                end
                ascp_pkg::ASCP_DONE: begin
                    // extra sck rises fall through here unused
                    state <= ascp_pkg::ASCP_DONE;
                end
                default: begin
                    state <= ascp_pkg::ASCP_IDLE;
                end
            endcase
        end
    end

    logic frame_done; // one cycle: sixteenth bit just landed
    assign frame_done = (state == ascp_pkg::ASCP_SHIFT) && sy.sck_rise
        && (bit_cnt == `ASCP_FRAME_BITS - 5'd1);
    logic [15:0] frame; // completed frame word
    assign frame = {shreg[14:0], sy.sdi};
    logic wr_frame; // write frame complete
    assign wr_frame = frame_done && !frame[15];

    // ------------------------------------------------------------------
    // register writes and software reset
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fmt <= `ASCP_FMT_RESET;
            soft_reset_bit <= 1'b0;
        end else begin
            soft_reset_bit <= 1'b0;
            if (wr_frame && is_index(frame[14:8],
                `ASCP_SOFT_RESET_CONTROL)) begin
                // only bit 7 acts; the rest are don't care
                if (frame[`ASCP_SOFT_RESET_BIT]) begin
                    fmt <= `ASCP_FMT_RESET;
                    soft_reset_bit <= 1'b1;
                end
            end else if (wr_frame && is_index(frame[14:8],
                `ASCP_FORMAT_AND_POWER_CONTROL)) begin
                fmt <= frame[7:0];
            end
        end
    end

    // brief sleep while the soft reset takes effect
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sleep_cnt <= 4'd0;
        end else if (soft_reset_bit) begin
            sleep_cnt <= `ASCP_SLEEP_PULSE;
        end else if (sleep_cnt != 4'd0) begin
            sleep_cnt <= sleep_cnt - 4'd1;
        end
    end

    // ------------------------------------------------------------------
    // readback on sdo
    // ------------------------------------------------------------------
    // index known after 8 bits; data bits follow msb first
    always_ff @(posedge ref_clk) begin
        if (!nrst || !serial_mode || sy.cs_rise) begin
            rd_active <= 1'b0;
            rd_data <= 8'h00;
        end else if (state == ascp_pkg::ASCP_SHIFT && sy.sck_rise
            && bit_cnt == `ASCP_DATA_START - 5'd1) begin
            // the register is read, never written, here
            rd_active <= shreg[6];
            // write-only reset register reads as zero
            rd_data <= is_index({shreg[5:0], sy.sdi},
                `ASCP_FORMAT_AND_POWER_CONTROL) ? fmt : 8'h00;
        end else if (rd_active && sy.sck_fall
            && state == ascp_pkg::ASCP_SHIFT
            && bit_cnt > `ASCP_DATA_START) begin
            rd_data <= {rd_data[6:0], 1'b0};
        end else if (state == ascp_pkg::ASCP_DONE && sy.sck_fall) begin
            rd_active <= 1'b0;
        end
    end

    // open drain: only ever pull low
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= rd_active && !rd_data[7]
                && state == ascp_pkg::ASCP_SHIFT;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sdo_out <= 1'b0;
        end else begin
            sdo_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // mode outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            duty_stabilizer_disable <= 1'b0;
            output_scramble_enable <= 1'b0;
            signed_coding_select <= 1'b0;
            sleep_all <= 1'b0;
            nap_channel <= 4'h0;
            two_lane_16bit <= 1'b1;
            drive_half_current <= 1'b0;
            term_enable <= 1'b0;
        end else if (serial_mode) begin
            duty_stabilizer_disable <= fmt[`ASCP_DUTY_STAB_DIS_BIT];
            output_scramble_enable <= fmt[`ASCP_SCRAMBLE_BIT];
            signed_coding_select <= fmt[`ASCP_SIGNED_BIT];
            sleep_all <= fmt[`ASCP_SLEEP_BIT] || sleep_cnt != 4'd0
                || soft_reset_bit;
            // sleep disables all channels regardless of nap bits
            nap_channel <= fmt[`ASCP_SLEEP_BIT] ? 4'hF : fmt[3:0];
            two_lane_16bit <= 1'b1;
            drive_half_current <= 1'b0;
            term_enable <= 1'b0;
        end else begin
            duty_stabilizer_disable <= 1'b0;
            output_scramble_enable <= 1'b0;
            signed_coding_select <= 1'b0;
            sleep_all <= sy.sdi;
            nap_channel <= 4'h0;
            two_lane_16bit <= !sy.cs_n;
            drive_half_current <= sy.sck;
            term_enable <= sy.sdo_in;
        end
    end

    // ------------------------------------------------------------------
    // output coding and scrambler
    // ------------------------------------------------------------------
    logic [13:0] coded; // coded, then optionally scrambled, sample
    // coding first, so the scrambler sees the final lsb
    always_comb begin
        coded = raw_data;
        coded[13] = raw_data[13] ^ signed_coding_select;
        if (output_scramble_enable) begin
            coded[13:1] = coded[13:1] ^ {13{coded[0]}};
        end
    end

    // one register stage so the output comes straight from a flop
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            scrambled_data <= 14'h0000;
        end else begin
            scrambled_data <= coded;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    reset_self_clear_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        soft_reset_bit |=> !soft_reset_bit)
        else $error("reset bit stayed set");
    reset_clears_fmt_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        soft_reset_bit && serial_mode |=> fmt == `ASCP_FMT_RESET
        && nap_channel == 4'h0 && !output_scramble_enable)
        else $error("soft reset left format register set");
    reset_sleeps_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        soft_reset_bit && serial_mode |=> sleep_all)
        else $error("soft reset did not sleep converter");
    sdo_never_high_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        sdo_out == 1'b0)
        else $error("sdo driven high");
    extra_edges_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        state == ascp_pkg::ASCP_DONE && !sy.cs_rise
        |=> $stable(shreg) && $stable(fmt))
        else $error("edge past sixteen had effect");
    cs_rise_idle_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        sy.cs_rise && serial_mode |=> state == ascp_pkg::ASCP_IDLE)
        else $error("frame not reset at chip select high");
    read_no_write_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        frame_done && frame[15] |=> $stable(fmt))
        else $error("readback changed a register");
    par_no_frame_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !serial_mode |=> state == ascp_pkg::ASCP_IDLE)
        else $error("framing active in parallel mode");
    write_fmt_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        wr_frame && frame[14:8] == `ASCP_FORMAT_AND_POWER_CONTROL
        |=> fmt == $past(frame[7:0]))
        else $error("write did not land");
    cov_write_c: cover property (@(posedge ref_clk) wr_frame);
    cov_read_c: cover property (@(posedge ref_clk) frame_done && frame[15]);
    cov_reset_c: cover property (@(posedge ref_clk) soft_reset_bit);
    cov_par_c: cover property (@(posedge ref_clk) !serial_mode && term_enable);
endmodule : ascp_serial_port
`default_nettype wire

// ==== tb/ascp_spi_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// spi host model with open-drain readback
// ----------------------------------------------------------------
module ascp_spi_host (
    input wire logic ref_clk,
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo
);
    // idle: deselected, link clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // wait whole bench clocks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    // static levels for parallel straps
    task automatic pins(input logic c, input logic k, input logic d);
        cs_n <= c;
        sck <= k;
        sdi <= d;
        tick(4);
    endtask : pins
    // one frame of n clocks; pins move by nba on a bench edge
    // extra clocks beyond the word send ones
    task automatic frame(input int n, input logic [15:0] w,
        output logic [7:0] rd);
        rd = 8'h00;
        cs_n <= 1'b0;
        sdi <= w[15]; // direction first
        tick(8);
        for (int i = 0; i < n; i++) begin
            sck <= 1'b1;
            tick(2);
            // sdi moves mid-high, so it is settled well before a rise
            sdi <= (i < 15) ? w[14 - i] : 1'b1;
            tick(1);
            // sample on the falling bench edge to avoid a race
            @(negedge ref_clk);
            if (i >= 8 && i < 16) rd = {rd[6:0], sdo};
            tick(1);
            sck <= 1'b0;
            tick(4);
        end
        tick(8);
        cs_n <= 1'b1;
        // data line inverted as chip select rises, not parked at a fixed level
        sdi <= ~sdi;
        tick(10);
    endtask : frame
endmodule : ascp_spi_host
`default_nettype wire

// ==== tb/adc_serial_config_port_test.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// bench for the adc serial configuration port
// ----------------------------------------------------------------
module adc_serial_config_port_test;
    logic ref_clk = 1'b0; // 50 MHz
    logic nrst = 1'b0; // sync reset
    logic strap = 1'b0; // low = serial
    logic sdo_strap = 1'b1; // pull-up, or driven level in parallel
    logic [13:0] raw = 14'h0000; // converter data in
    logic cs_n, sck, sdi, sdo_out, sdo_oe, sdo_wire;
    logic dsd, scr, sgn, slp, two, half, term;
    logic saw_sleep = 1'b0; // sleep seen since last clear
    logic [3:0] nap;
    logic [13:0] scrd, e;
    logic [7:0] rd;
    int mismatches = 0;
    int n_compared = 0;
    // open-drain wire: low when pulled, else pull-up or strap
    assign sdo_wire = (sdo_oe === 1'b1) ? sdo_out : sdo_strap;
    always #10 ref_clk = ~ref_clk;
    // latch any sleep pulse between two checks
    always @(posedge ref_clk) begin
        if (slp === 1'b1) saw_sleep <= 1'b1;
    end
    ascp_serial_port u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .port_style_strap(strap),
        .cs_n_pin(cs_n), .sck_pin(sck), .sdi_pin(sdi),
        .sdo_pin_in(sdo_wire), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .duty_stabilizer_disable(dsd), .output_scramble_enable(scr),
        .signed_coding_select(sgn), .sleep_all(slp),
        .nap_channel(nap), .two_lane_16bit(two),
        .drive_half_current(half), .term_enable(term),
        .scrambled_data(scrd), .raw_data(raw)
    );
    ascp_spi_host u_host (
        .ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo(sdo_wire)
    );
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.frame(16, {1'b0, a, d}, rd);
    endtask : wr
    // read with all-ones data bits, which must be disregarded
    task automatic rdreg(input logic [6:0] a, input logic [7:0] exp);
        u_host.frame(16, {1'b1, a, 8'hFF}, rd);
        chk("readback", 16'(exp), 16'(rd));
    endtask : rdreg
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // first command is the software reset; converter must sleep briefly
    task automatic t_first_reset();
        saw_sleep <= 1'b0;
        wr(7'h00, 8'h80);
        chk("reset sleep", 16'h1, 16'(saw_sleep));
        rdreg(7'h01, 8'h00);
    endtask : t_first_reset
    task automatic t_fields();
        wr(7'h01, 8'hA5);
        chk("stab off", 16'h1, 16'(dsd));
        chk("scramble", 16'h0, 16'(scr));
        chk("signed", 16'h1, 16'(sgn));
        chk("sleep", 16'h0, 16'(slp));
        chk("nap", 16'h5, 16'(nap));
        rdreg(7'h01, 8'hA5);
        rdreg(7'h01, 8'hA5);
    endtask : t_fields
    // twenty clocks, then an aborted eight-clock frame
    task automatic t_excess_abort();
        u_host.frame(20, {1'b0, 7'h01, 8'h3C}, rd);
        chk("sleep bit", 16'h1, 16'(slp));
        chk("nap all", 16'hF, 16'(nap));
        u_host.frame(8, {1'b0, 7'h01, 8'h00}, rd);
        rdreg(7'h01, 8'h3C);
    endtask : t_excess_abort
    task automatic t_reset_reg();
        wr(7'h00, 8'h7F);
        rdreg(7'h01, 8'h3C);
        wr(7'h00, 8'h80);
        rdreg(7'h01, 8'h00);
        rdreg(7'h00, 8'h00);
        saw_sleep <= 1'b0;
        wr(7'h01, 8'h40);
        chk("no resleep", 16'h0, 16'(saw_sleep));
        rdreg(7'h01, 8'h40);
    endtask : t_reset_reg
    // coding then scrambling of one sample for a given format
    task automatic t_data(input logic [7:0] f, input logic [13:0] v);
        wr(7'h01, f);
        @(posedge ref_clk);
        raw <= v;
        u_host.tick(4);
        e = f[5] ? (v ^ 14'h2000) : v;
        if (f[6]) e = e ^ {{13{e[0]}}, 1'b0};
        chk("data out", 16'(e), 16'(scrd));
    endtask : t_data
    task automatic t_parallel();
        @(posedge ref_clk);
        strap <= 1'b1;
        sdo_strap <= 1'b1;
        u_host.pins(1'b0, 1'b1, 1'b1);
        u_host.tick(10);
        chk("two lane", 16'h1, 16'(two));
        chk("half cur", 16'h1, 16'(half));
        chk("par sleep", 16'h1, 16'(slp));
        chk("term", 16'h1, 16'(term));
        chk("par scr", 16'h0, 16'(scr));
        u_host.frame(16, {1'b0, 7'h01, 8'hFF}, rd);
        @(posedge ref_clk);
        sdo_strap <= 1'b0;
        u_host.pins(1'b1, 1'b0, 1'b0);
        u_host.tick(10);
        chk("one lane", 16'h0, 16'(two));
        chk("full cur", 16'h0, 16'(half));
        chk("par awake", 16'h0, 16'(slp));
        chk("no term", 16'h0, 16'(term));
        @(posedge ref_clk);
        strap <= 1'b0;
        sdo_strap <= 1'b1;
        u_host.tick(10);
        rdreg(7'h01, 8'h60);
    endtask : t_parallel
    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        u_host.tick(10);
        t_first_reset();
        t_fields();
        t_excess_abort();
        t_reset_reg();
        t_data(8'h00, 14'h2A55);
        t_data(8'h40, 14'h2A55);
        t_data(8'h20, 14'h1C3A);
        t_data(8'h60, 14'h0001);
        t_parallel();
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        complete_run();
    end
endmodule : adc_serial_config_port_test
`default_nettype wire
